// ===== verilog/ahg_pkg.sv
package ahg_pkg;
    // ****************************************************************
    // register map (word offsets are byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_GEAR_RATIO   = 8'h00;
    localparam logic [7:0] OFF_CONFIG       = 8'h04;
    localparam logic [7:0] OFF_SLEW_SPEED   = 8'h08;
    localparam logic [7:0] OFF_HOMING_SPEED = 8'h0C;
    localparam logic [7:0] OFF_COMMAND      = 8'h10;
    localparam logic [7:0] OFF_STATUS       = 8'h14;
    localparam logic [7:0] OFF_POSITION     = 8'h18;
    localparam logic [7:0] OFF_MASTER_POS   = 8'h1C;
    // config field positions
    localparam int CFG_COUPLE_BIT   = 0;
    localparam int CFG_POLARITY_BIT = 1;
    localparam int CFG_STEPPER_BIT  = 2;
    // command bits (write one to act)
    localparam int CMD_HOME_SEL_BIT = 0;
    localparam int CMD_BEGIN_BIT    = 1;
    localparam int CMD_STOP_BIT     = 2;
    // gear ratio: signed 8.16 fixed point, range -127..127
    localparam logic signed [31:0] GEAR_MAX     = 32'sh007F_0000;
    localparam logic signed [31:0] GEAR_MIN     = -32'sh007F_0000;
    localparam logic [31:0]        GEAR_RESET   = 32'h0000_0000;
    localparam int                 GEAR_FRAC    = 16;
    // speeds in counts per second
    localparam logic [31:0] HSPEED_RESET   = 32'h0000_0100;
    localparam logic [31:0] HSPEED_SERVO   = 32'h00E4_E1C0;
    localparam logic [31:0] HSPEED_STEPPER = 32'h002D_C6C0;
    localparam logic [31:0] SSPEED_RESET   = 32'h0000_0100;
    localparam logic [31:0] SPEED_HALFSTEP = 32'hFFFF_FFFE;
    // speed accumulator: counts/s scaled to one 125 MHz sample
    localparam int CLK_HZ = 125_000_000;
    localparam logic [31:0] CLK_HZ_W = 32'h0773_5940;
    // deceleration step per sample on the stage speed
    localparam logic [31:0] DECEL_STEP = 32'h0000_0001;

    typedef enum {
        HM_IDLE, HM_FAST, HM_DECEL, HM_BACK, HM_INDEX, HM_RETURN
    } ahg_state_t;

    typedef struct packed {
        logic        homeLevel;
        logic        limitHit;
        logic        indexLatched;
        logic [31:0] indexPos;
        logic [31:0] masterPos;
    } ahg_sense_t;
endpackage

// ===== verilog/ahg_axis.sv
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// ****************************************************************
// axis homing and gearing
// ****************************************************************
module ahg_axis
    import ahg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire ahg_sense_t  sense,
    output logic      [31:0] commandPos,
    output logic             motionComplete,
    output logic             homeStateFlag
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic signed [31:0] gearRatio_r, gearRatio_nxt;
    logic [2:0]         config_r, config_nxt;
    logic [31:0]        slewSpeed_r, slewSpeed_nxt;
    logic [31:0]        homingSpeed_r, homingSpeed_nxt;
    logic               homeSel_r, homeSel_nxt;
    logic               gearOn_r, gearOn_nxt;
    logic               done_r, done_nxt;
    logic               dirBack_r, dirBack_nxt;
    logic               homeLast_r, homeLast_nxt;
    logic [31:0]        speed_r, speed_nxt;
    logic [31:0]        acc_r, acc_nxt;
    logic signed [31:0] pos_r, pos_nxt;
    logic signed [47:0] gearFrac_r, gearFrac_nxt;
    logic [31:0]        masterLast_r, masterLast_nxt;
    logic signed [31:0] target_r, target_nxt;
    logic [31:0]        rdData_r, rdData_nxt;
    logic               ack_r, ack_nxt;
    ahg_state_t         state_r, state_nxt;

    logic        wrStb;
    logic        couple;
    logic        polarityPos;
    logic        stepper;
    logic        homeFlag;
    logic        edgeSeen;
    logic        stepTick;
    logic [32:0] accSum;
    logic signed [31:0] masterDelta;
    logic signed [63:0] gearProd;
    logic signed [47:0] gearSum;
    logic [31:0] speedCap;
    logic [31:0] wrSpeed;

    assign couple      = config_r[CFG_COUPLE_BIT];
    assign polarityPos = config_r[CFG_POLARITY_BIT];
    assign stepper     = config_r[CFG_STEPPER_BIT];
    // flag follows level for polarity -1, inverted for +1
    assign homeFlag    = polarityPos ? ~sense.homeLevel : sense.homeLevel;
    assign edgeSeen    = sense.homeLevel != homeLast_r;
    // a write lands at the edge where the master samples ack high, not before
    assign wrStb       = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign speedCap    = stepper ? HSPEED_STEPPER : HSPEED_SERVO;
    assign wrSpeed     = wb_dat_i & SPEED_HALFSTEP;
    // step pacing: one count each time the accumulator overflows the clock rate
    assign accSum      = {1'b0, acc_r} + {1'b0, speed_r};
    assign stepTick    = (state_r != HM_IDLE) && (accSum >= {1'b0, CLK_HZ_W});
    assign masterDelta = $signed(sense.masterPos - masterLast_r);
    assign gearProd    = masterDelta * gearRatio_r;
    assign gearSum     = gearFrac_r + gearProd[47:0];

    // ****************************************************************
    // register bus and homing sequencer next state
    // ****************************************************************
    always_comb begin
        gearRatio_nxt   = gearRatio_r;
        config_nxt      = config_r;
        slewSpeed_nxt   = slewSpeed_r;
        homingSpeed_nxt = homingSpeed_r;
        homeSel_nxt     = homeSel_r;
        gearOn_nxt      = gearOn_r;
        done_nxt        = done_r;
        dirBack_nxt     = dirBack_r;
        homeLast_nxt    = sense.homeLevel;
        speed_nxt       = speed_r;
        acc_nxt         = acc_r;
        pos_nxt         = pos_r;
        gearFrac_nxt    = gearFrac_r;
        masterLast_nxt  = sense.masterPos;
        target_nxt      = target_r;
        state_nxt       = state_r;
        ack_nxt         = wb_cyc_i && wb_stb_i && !ack_r;
        rdData_nxt      = 32'h0000_0000;

        // gearing: follows master only while engaged and not homing
        if (gearOn_r && state_r == HM_IDLE) begin
            // floor split: the kept remainder is never negative
            gearFrac_nxt = {32'h0000_0000, gearSum[GEAR_FRAC-1:0]};
            pos_nxt      = pos_r + gearSum[47:GEAR_FRAC];
        end
        // stepping at the current stage speed
        if (state_r != HM_IDLE) begin
            acc_nxt = stepTick ? accSum[31:0] - CLK_HZ_W : accSum[31:0];
            if (stepTick) begin
                pos_nxt = dirBack_r ? pos_r - 32'sd1 : pos_r + 32'sd1;
            end
        end

        case (state_r)
            HM_IDLE: begin
            end
            HM_FAST: begin
                if (edgeSeen) begin
                    state_nxt = HM_DECEL;
                end
            end
            HM_DECEL: begin
                // ramp down before reversing
                if (speed_r > DECEL_STEP) begin
                    speed_nxt = speed_r - DECEL_STEP;
                end else begin
                    speed_nxt   = homingSpeed_r;
                    dirBack_nxt = ~dirBack_r;
                    acc_nxt     = 32'h0000_0000;
                    state_nxt   = HM_BACK;
                end
            end
            HM_BACK: begin
                if (edgeSeen) begin
                    // accumulator cleared, no ramp; stepper stops, servo turns forward to seek the index
                    acc_nxt = 32'h0000_0000;
                    if (stepper) begin
                        speed_nxt = 32'h0000_0000;
                        state_nxt = HM_IDLE;
                        done_nxt  = 1'b1;
                    end else begin
                        dirBack_nxt = 1'b0;
                        state_nxt   = HM_INDEX;
                    end
                end
            end
            HM_INDEX: begin
                if (sense.indexLatched) begin
                    target_nxt = $signed(sense.indexPos);
                    state_nxt  = HM_RETURN;
                    dirBack_nxt = 1'b1;
                end
            end
            HM_RETURN: begin
                if (pos_r <= target_r) begin
                    pos_nxt   = 32'sd0;
                    speed_nxt = 32'h0000_0000;
                    state_nxt = HM_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = HM_IDLE;
            end
        endcase

        // bus writes
        if (wrStb && wb_sel_i == 4'hF) begin
            case (wb_adr_i)
                OFF_GEAR_RATIO: begin
                    // clamp to the legal ratio span
                    if ($signed(wb_dat_i) > GEAR_MAX) begin
                        gearRatio_nxt = GEAR_MAX;
                    end else if ($signed(wb_dat_i) < GEAR_MIN) begin
                        gearRatio_nxt = GEAR_MIN;
                    end else begin
                        gearRatio_nxt = $signed(wb_dat_i);
                    end
                    gearOn_nxt   = wb_dat_i != 32'h0000_0000;
                    gearFrac_nxt = 48'sd0;
                end
                OFF_CONFIG: begin
                    config_nxt = wb_dat_i[2:0];
                end
                OFF_SLEW_SPEED: begin
                    slewSpeed_nxt = wrSpeed;
                end
                OFF_HOMING_SPEED: begin
                    // even values only, capped per motor type
                    homingSpeed_nxt = (wrSpeed > speedCap) ? speedCap : wrSpeed;
                end
                OFF_COMMAND: begin
                    if (wb_dat_i[CMD_HOME_SEL_BIT]) begin
                        homeSel_nxt = 1'b1;
                    end
                    if (wb_dat_i[CMD_BEGIN_BIT] && homeSel_r && state_r == HM_IDLE) begin
                        homeSel_nxt = 1'b0;
                        done_nxt    = 1'b0;
                        dirBack_nxt = homeFlag;
                        speed_nxt   = slewSpeed_r;
                        acc_nxt     = 32'h0000_0000;
                        state_nxt   = HM_FAST;
                    end
                    if (wb_dat_i[CMD_STOP_BIT]) begin
                        if (!couple) begin
                            gearOn_nxt = 1'b0;
                        end
                        if (state_r != HM_IDLE) begin
                            state_nxt = HM_IDLE;
                            speed_nxt = 32'h0000_0000;
                        end
                    end
                end
                OFF_POSITION: begin
                    pos_nxt = $signed(wb_dat_i);
                end
                default: begin
                end
            endcase
        end

        // disengage on limit unless strongly coupled; the limit beats a ratio write
        if (sense.limitHit && !couple) begin
            gearOn_nxt = 1'b0;
        end

        // read mux, unmapped reads return zero
        case (wb_adr_i)
            OFF_GEAR_RATIO:   rdData_nxt = gearRatio_r;
            OFF_CONFIG:       rdData_nxt = {29'h0000_0000, config_r};
            OFF_SLEW_SPEED:   rdData_nxt = slewSpeed_r;
            OFF_HOMING_SPEED: rdData_nxt = homingSpeed_r;
            OFF_STATUS:       rdData_nxt = {27'h0000_0000, homeFlag, gearOn_r,
                                            homeSel_r, state_r != HM_IDLE, done_r};
            OFF_POSITION:     rdData_nxt = pos_r;
            OFF_MASTER_POS:   rdData_nxt = sense.masterPos;
            default:          rdData_nxt = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gearRatio_r   <= GEAR_RESET;
            config_r      <= 3'b000;
            slewSpeed_r   <= SSPEED_RESET;
            homingSpeed_r <= HSPEED_RESET;
            homeSel_r     <= 1'b0;
            gearOn_r      <= 1'b0;
            done_r        <= 1'b1;
            dirBack_r     <= 1'b0;
            homeLast_r    <= 1'b1;    // pulled-up idle level, no false edge
            speed_r       <= 32'h0000_0000;
            acc_r         <= 32'h0000_0000;
            pos_r         <= 32'sd0;
            gearFrac_r    <= 48'sd0;
            masterLast_r  <= 32'h0000_0000;
            target_r      <= 32'sd0;
            rdData_r      <= 32'h0000_0000;
            ack_r         <= 1'b0;
            state_r       <= HM_IDLE;
        end else begin
            gearRatio_r   <= gearRatio_nxt;
            config_r      <= config_nxt;
            slewSpeed_r   <= slewSpeed_nxt;
            homingSpeed_r <= homingSpeed_nxt;
            homeSel_r     <= homeSel_nxt;
            gearOn_r      <= gearOn_nxt;
            done_r        <= done_nxt;
            dirBack_r     <= dirBack_nxt;
            homeLast_r    <= homeLast_nxt;
            speed_r       <= speed_nxt;
            acc_r         <= acc_nxt;
            pos_r         <= pos_nxt;
            gearFrac_r    <= gearFrac_nxt;
            masterLast_r  <= masterLast_nxt;
            target_r      <= target_nxt;
            rdData_r      <= rdData_nxt;
            ack_r         <= ack_nxt;
            state_r       <= state_nxt;
        end
    end

    assign wb_dat_o       = rdData_r;
    assign wb_ack_o       = ack_r;
    assign commandPos     = pos_r;
    assign motionComplete = done_r;
    assign homeStateFlag  = homeFlag;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_edge_fast;
        state_r == HM_FAST && edgeSeen;
    endsequence

    a_ratio_range: assert property (@(posedge sys_clk) disable iff (rst)
        gearRatio_r <= GEAR_MAX && gearRatio_r >= GEAR_MIN)
        else $error("gear ratio out of range");
    a_zero_gear_off: assert property (@(posedge sys_clk) disable iff (rst)
        gearRatio_r == 32'sd0 |-> !gearOn_r)
        else $error("gearing on with zero ratio");
    a_limit_disengage: assert property (@(posedge sys_clk) disable iff (rst)
        sense.limitHit && !couple |=> !gearOn_r)
        else $error("gearing held past limit");
    a_stage_one_decel: assert property (@(posedge sys_clk) disable iff (rst)
        s_edge_fast |=> state_r == HM_DECEL)
        else $error("no deceleration after home edge");
    a_stepper_two_stage: assert property (@(posedge sys_clk) disable iff (rst)
        stepper |-> state_r != HM_INDEX || $past(state_r) == HM_INDEX)
        else $error("stepper entered index stage");
    a_back_instant_stop: assert property (@(posedge sys_clk) disable iff (rst)
        state_r == HM_BACK && edgeSeen |=> acc_r == 32'h0000_0000)
        else $error("stage two did not stop at once");
    a_home_speed_cap: assert property (@(posedge sys_clk) disable iff (rst)
        homingSpeed_r <= HSPEED_SERVO && homingSpeed_r[0] == 1'b0)
        else $error("homing speed illegal");
    a_return_zero: assert property (@(posedge sys_clk) disable iff (rst)
        state_r == HM_RETURN && pos_r <= target_r |=> pos_r == 32'sd0 && done_r)
        else $error("position not zeroed at index");
endmodule

// ===== tb/ahg_motor_model.sv
`timescale 1ns/1ps
// ****************************************************************
// motor, home switch and encoder stand-in
// ****************************************************************
module ahg_motor_model #(
    parameter int INDEX_POS = 6
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [31:0] commandPos,
    input  wire logic        limitReq,
    output logic             homeLevel,
    output logic             limitHit,
    output logic             indexLatched,
    output logic      [31:0] indexPos
);
    logic [31:0] latPos_r;
    // switch edge sits between count -1 and count 0
    assign homeLevel = ~commandPos[31];
    assign limitHit  = limitReq;
    // latched value means nothing while the flag is down, so show junk
    assign indexPos  = indexLatched ? latPos_r : ~latPos_r;
    // index latch re-arms once the axis goes back past the switch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            indexLatched <= 1'b0;
            latPos_r     <= 32'h0000_0000;
        end else if (commandPos[31]) begin
            indexLatched <= 1'b0;
        end else if (!indexLatched && $signed(commandPos) == INDEX_POS) begin
            indexLatched <= 1'b1;
            latPos_r     <= commandPos;
        end
    end
endmodule

// ===== tb/axis_homing_and_gearing_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// bench for the axis homing and gearing block
// ****************************************************************
module axis_homing_and_gearing_tb_top import ahg_pkg::*;;
    logic        sys_clk, rst, wbWe, wbCyc, wbStb, wbAck, limitReq;
    logic        homeLevel, limitHit, idxLat, motionComplete, homeStateFlag;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI, wbDatO, commandPos, masterPos, idxPos;
    ahg_sense_t  sense;
    logic [31:0] expQ[$];
    logic [7:0]  adrQ[$];
    int          mismatches, num_checks;

    assign sense = '{homeLevel, limitHit, idxLat, idxPos, masterPos};

    ahg_axis ahg_axis_inst (
        .sys_clk(sys_clk), .rst(rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_ack_o(wbAck), .sense(sense), .commandPos(commandPos),
        .motionComplete(motionComplete), .homeStateFlag(homeStateFlag)
    );
    ahg_motor_model ahg_motor_model_inst (
        .sys_clk(sys_clk), .rst(rst), .commandPos(commandPos), .limitReq(limitReq),
        .homeLevel(homeLevel), .limitHit(limitHit), .indexLatched(idxLat),
        .indexPos(idxPos)
    );

    // 125 MHz sample clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one classic cycle; a read leaves its expectation for the monitor
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        @(posedge sys_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbAdr  <= a;
        wbDatI <= d;
        wbSel  <= 4'hF;
        if (!w) begin
            expQ.push_back(e);
            adrQ.push_back(a);
        end
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbx(1'b1, a, d, 32'h0000_0000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h0000_0000, e);
    endtask

    // read data is judged at the very edge the master takes it
    always @(posedge sys_clk) begin
        if (wbAck === 1'b1 && wbCyc && !wbWe) begin
            chk($sformatf("read %h", adrQ.pop_front()), wbDatO, expQ.pop_front());
        end
    end

    // full homing run; the switch edge is one count behind the start
    task automatic home_run(input logic stp, input logic [31:0] hv, input logic [31:0] hx);
        logic [31:0] minPos;
        int          n;
        minPos = 32'h0000_0000;
        n = 0;
        wr(OFF_CONFIG, 32'(stp) << CFG_STEPPER_BIT);
        wr(OFF_HOMING_SPEED, hv);
        rd(OFF_HOMING_SPEED, hx);
        wr(OFF_SLEW_SPEED, 32'h0000_0FA0);
        wr(OFF_POSITION, 32'h0000_0000);
        wr(OFF_COMMAND, 32'h0000_0001);
        wr(OFF_COMMAND, 32'h0000_0002);
        tick(2);
        chk("complete early", 32'(motionComplete), 32'h0000_0000);
        while (motionComplete !== 1'b1 && n < 60000) begin
            @(posedge sys_clk);
            n++;
            if ($signed(commandPos) < $signed(minPos)) minPos = commandPos;
        end
        chk("homing finished", 32'(motionComplete), 32'h0000_0001);
        chk("deepest position", minPos, 32'hFFFF_FFFF);
        chk("index used", 32'(idxLat), 32'(!stp));
        chk("home position", commandPos, 32'h0000_0000);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int r, d;
        logic [31:0] rw, ex;
        rst = 1'b1;
        {wbWe, wbCyc, wbStb, limitReq} = 4'h0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatI = 32'h0000_0000;
        masterPos = 32'h0000_0000;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(32'h31ec));
        tick(10);
        rst <= 1'b0;
        rd(OFF_GEAR_RATIO, GEAR_RESET);
        rd(OFF_CONFIG, 32'h0000_0000);
        rd(OFF_HOMING_SPEED, HSPEED_RESET);
        rd(8'h40, 32'h0000_0000);
        // done after reset, idle, nothing selected, gearing off, flag high
        rd(OFF_STATUS, 32'h0000_0011);
        wr(OFF_HOMING_SPEED, 32'h0131_2D01);
        rd(OFF_HOMING_SPEED, HSPEED_SERVO);
        wr(OFF_GEAR_RATIO, 32'h0080_0000);
        rd(OFF_GEAR_RATIO, GEAR_MAX);
        wr(OFF_GEAR_RATIO, 32'hFF80_0000);
        rd(OFF_GEAR_RATIO, GEAR_MIN);
        wr(OFF_GEAR_RATIO, 32'h0000_0000);
        // flag against both polarities on both sides of the switch
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 2; s++) begin
                wr(OFF_CONFIG, 32'(p) << CFG_POLARITY_BIT);
                wr(OFF_POSITION, s ? 32'h0000_0005 : 32'hFFFF_FFFB);
                tick(2);
                chk("home flag", 32'(homeStateFlag), 32'(s ^ p));
            end
        end
        // first ratio is one half, the rest random whole ratios
        for (int i = 0; i < 4; i++) begin
            r = int'($urandom_range(254)) - 127;
            d = 2 * int'($urandom_range(200)) - 200;
            rw = (i == 0) ? 32'h0000_8000 : 32'(r) << GEAR_FRAC;
            ex = (i == 0) ? 32'(d / 2) : 32'(r * d);
            wr(OFF_POSITION, 32'h0000_0000);
            wr(OFF_GEAR_RATIO, rw);
            masterPos <= masterPos + 32'(d);
            tick(8);
            rd(OFF_POSITION, ex);
        end
        // stop, stop when coupled, limit, zero ratio
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CONFIG, 32'(c == 1));
            wr(OFF_POSITION, 32'h0000_0000);
            wr(OFF_GEAR_RATIO, (c == 3) ? 32'h0000_0000 : 32'h0001_0000);
            if (c < 2) wr(OFF_COMMAND, 32'h0000_0004);
            limitReq <= (c == 2);
            tick(2);
            masterPos <= masterPos + 32'h0000_0064;
            tick(8);
            rd(OFF_POSITION, (c == 1) ? 32'h0000_0064 : 32'h0000_0000);
            limitReq <= 1'b0;
        end
        wr(OFF_GEAR_RATIO, 32'h0000_0000);
        rd(OFF_MASTER_POS, masterPos);
        home_run(1'b0, 32'h00BE_BC20, 32'h00BE_BC20);
        home_run(1'b1, 32'h003D_0900, HSPEED_STEPPER);
        give_verdict();
    end

    // hang guard sized above two homing runs
    initial begin
        repeat (95000) @(posedge sys_clk);
        mismatches++;
        give_verdict();
    end
endmodule
